// [src/gpb_pkg.sv]
// Shared constants for the port B, C and D pin logic
package gpb_pkg;

   // ****************************************
   // Register indices (byte address = 4 * index)
   // ****************************************
   localparam logic [5:0] IDX_PORT_B_LATCH = 6'h01;
   localparam logic [5:0] IDX_PORT_C_LATCH = 6'h02;
   localparam logic [5:0] IDX_PORT_D_LATCH = 6'h03;
   localparam logic [5:0] IDX_PORT_B_DIR = 6'h05;
   localparam logic [5:0] IDX_PORT_C_DIR = 6'h06;
   localparam logic [5:0] IDX_PORT_D_DIR = 6'h07;
   localparam logic [5:0] IDX_PORT_C_PUE = 6'h0e;
   localparam logic [5:0] IDX_PORT_D_PUE = 6'h0f;

   // ****************************************
   // Widths and reset values
   // ****************************************
   localparam int ADDR_W = 8;
   localparam int WORD_LSB = 2;
   localparam int PB_W = 8;
   localparam int PC_W = 7;
   localparam int PD_W = 8;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

   // ****************************************
   // Alternate pin positions
   // ****************************************
   localparam int PC_CAN_RX = 1;
   localparam int PC_CAN_TX = 0;
   localparam int PD_SPI_SS = 0;
   localparam int PD_TIMER_LSB = 4;
   localparam int TIMER_CHANS = 4;
   localparam int SPI_PINS = 4;

endpackage

// [src/gpb_pin_mux.sv]
// Per-pin ownership, drive, pullup and read-back selection
`timescale 1ns/1ps
`default_nettype none

module gpb_pin_mux #(
   parameter int W = 8
) (
   input wire logic [W-1:0] latch,
   input wire logic [W-1:0] dir,
   input wire logic [W-1:0] pue,
   input wire logic [W-1:0] alt_own,
   input wire logic [W-1:0] alt_oe,
   input wire logic [W-1:0] alt_out,
   input wire logic [W-1:0] pin_in,
   output logic [W-1:0] next_oe,
   output logic [W-1:0] next_out,
   output logic [W-1:0] next_pullup,
   output logic [W-1:0] rd_val
);

   // ****************************************
   // Pin selection
   // ****************************************

   // Owner peripheral overrides direction, else direction bit drives
   always_comb begin
      next_oe = (alt_own & alt_oe) | (~alt_own & dir);
      next_out = ((alt_own & alt_out) | (~alt_own & latch)) & next_oe;
   end

   // Pullup only while enabled, direction input and not driven
   always_comb begin
      next_pullup = pue & ~dir & ~next_oe;
   end

   // Direction bit picks latch or pin level, even for owned pins
   always_comb begin
      rd_val = (dir & latch) | (~dir & pin_in);
   end

endmodule

`default_nettype wire

// [src/gpb_gpio_ports.sv]
// Port B, C and D data and direction, port C and D pullup logic behind an APB slave
//
// Operation
// R1 - Port B read gives latch where direction 1, pin level where 0
// R2 - Data latches always writable; input pins read unaffected by latch writes
// R3 - Port C has seven pins with latch, direction and pullup
// R4 - Port C latches keep their contents through reset
// R5 - Port C direction 1 drives latch onto pin, 0 makes input
// R6 - Reset clears all port C direction bits
// R7 - Port C read gives latch for outputs, pin level for inputs
// R8 - Port C pullup only when enabled and pin is input
// R9 - Each port C pullup enable bit connects its own pullup
// R10 - CAN enable hands port C pins 1 and 0 to CAN
// R11 - Port D has eight pins shared with SPI and timers
// R12 - Port D latches at their index and keep contents through reset
// R13 - Timer edge/level selects claim port D timer pins
// R14 - SPI enable gives port D bit 3 to serial clock
// R15 - SPI enable gives port D bit 2 to MOSI
// R16 - SPI enable gives port D bit 1 to MISO
// R17 - SPI-owned pins ignore direction, direction still selects read-back
// R18 - Port D bit 0 is slave select when SPI enabled, not master
// R19 - Software loads latch before switching a pin to output
// R20 - Port D read gives latch for outputs, pin level for inputs
// R21 - Port D pullup only when enabled and pin is input
// R22 - Unused port C bit 7 reads zero and ignores writes
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module gpb_gpio_ports (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Port B pins
   input wire logic [7:0] port_b_pin_in,
   output logic [7:0] port_b_pin_out,
   output logic [7:0] port_b_pin_oe,
   // Port C pins
   input wire logic [6:0] port_c_pin_in,
   output logic [6:0] port_c_pin_out,
   output logic [6:0] port_c_pin_oe,
   output logic [6:0] port_c_pullup,
   // Port D pins
   input wire logic [7:0] port_d_pin_in,
   output logic [7:0] port_d_pin_out,
   output logic [7:0] port_d_pin_oe,
   output logic [7:0] port_d_pullup,
   // CAN controller
   input wire logic can_pin_enable,
   input wire logic can_tx,
   output logic can_rx,
   // SPI module, index equals port D bit
   input wire logic spi_enable_bit,
   input wire logic spi_master_select,
   input wire logic [3:0] spi_pin_oe,
   input wire logic [3:0] spi_pin_out,
   // Timer modules, index 3..0 is port D bit 7..4
   input wire logic [7:0] edge_level_select,
   input wire logic [3:0] timer_pin_oe,
   input wire logic [3:0] timer_pin_out,
   // Sampled port D levels for SPI and timer inputs
   output logic [7:0] port_d_pin_level
);

   // ****************************************
   // Functions
   // ****************************************

   // Register index of an APB byte address
   function automatic logic [5:0] reg_index(input logic [7:0] addr);
      reg_index = addr[7:gpb_pkg::WORD_LSB];
   endfunction

   // Timer channel claims its pin when its select pair is nonzero
   function automatic logic chan_active(input logic [7:0] els, input int k);
      chan_active = |els[2*k +: 2];
   endfunction

   // ****************************************
   // Declarations
   // ****************************************

   logic [7:0] port_b_latch;
   logic [7:0] port_b_direction;
   logic [6:0] port_c_latch;
   logic [6:0] port_c_direction;
   logic [6:0] port_c_pullup_enable;
   logic [7:0] port_d_latch;
   logic [7:0] port_d_direction;
   logic [7:0] port_d_pullup_enable;

   logic setup;
   logic wr_en;
   logic [5:0] idx;
   logic [5:0] acc_idx;
   logic mapped;
   logic [7:0] rd_byte;

   logic [6:0] pc_own;
   logic [6:0] pc_alt_oe;
   logic [6:0] pc_alt_out;
   logic [7:0] pd_own;
   logic [7:0] pd_alt_oe;
   logic [7:0] pd_alt_out;
   logic [3:0] spi_own;
   logic [3:0] tim_own;

   logic [7:0] next_b_oe;
   logic [7:0] next_b_out;
   logic [7:0] b_rd;
   logic [6:0] next_c_oe;
   logic [6:0] next_c_out;
   logic [6:0] next_c_pullup;
   logic [6:0] c_rd;
   logic [7:0] next_d_oe;
   logic [7:0] next_d_out;
   logic [7:0] next_d_pullup;
   logic [7:0] d_rd;

   // ****************************************
   // APB decode
   // ****************************************

   // Setup decode for the answer, access decode for the write
   always_comb begin
      setup = psel & ~penable;
      idx = reg_index(paddr);
      acc_idx = reg_index(paddr);
      wr_en = psel & penable & pready & pwrite & pstrb[0] & ~|paddr[gpb_pkg::WORD_LSB-1:0];
   end

   // Read value of the addressed register
   always_comb begin
      mapped = 1'b1;
      rd_byte = gpb_pkg::CTRL_RESET;
      case (idx)
         gpb_pkg::IDX_PORT_B_LATCH: rd_byte = b_rd; // R1
         gpb_pkg::IDX_PORT_C_LATCH: rd_byte = {1'b0, c_rd}; // R7 R22
         gpb_pkg::IDX_PORT_D_LATCH: rd_byte = d_rd; // R20 R17
         gpb_pkg::IDX_PORT_B_DIR: rd_byte = port_b_direction;
         gpb_pkg::IDX_PORT_C_DIR: rd_byte = {1'b0, port_c_direction}; // R22
         gpb_pkg::IDX_PORT_D_DIR: rd_byte = port_d_direction;
         gpb_pkg::IDX_PORT_C_PUE: rd_byte = {1'b0, port_c_pullup_enable}; // R22
         gpb_pkg::IDX_PORT_D_PUE: rd_byte = port_d_pullup_enable;
         default: mapped = 1'b0;
      endcase
      if (paddr[1:0] != 2'h0) begin
         mapped = 1'b0;
      end
   end

   // Answer one cycle after setup, with data and error flag
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pready <= 1'b0;
         prdata <= gpb_pkg::RDATA_ZERO;
         pslverr <= 1'b0;
      end else if (ce) begin
         pready <= setup;
         if (setup) begin
            prdata <= mapped ? {24'h00_0000, rd_byte} : gpb_pkg::RDATA_ZERO;
            pslverr <= ~mapped;
         end else begin
            pslverr <= 1'b0;
         end
      end
   end

   // ****************************************
   // Data latches
   // ****************************************

   // No reset: contents survive system reset, writes ignore direction
   always_ff @(posedge clk) begin
      if (ce && wr_en) begin
         case (acc_idx)
            gpb_pkg::IDX_PORT_B_LATCH: port_b_latch <= pwdata[7:0]; // R2
            gpb_pkg::IDX_PORT_C_LATCH: port_c_latch <= pwdata[6:0]; // R2 R4 R22
            gpb_pkg::IDX_PORT_D_LATCH: port_d_latch <= pwdata[7:0]; // R2 R12
            default: ;
         endcase
      end
   end

   // ****************************************
   // Direction and pullup enables
   // ****************************************

   // Cleared by reset, so every pin not owned by CAN, SPI or a timer starts as an input
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         port_b_direction <= gpb_pkg::CTRL_RESET;
         port_c_direction <= gpb_pkg::CTRL_RESET[6:0]; // R6
         port_d_direction <= gpb_pkg::CTRL_RESET;
      end else if (ce && wr_en) begin
         case (acc_idx)
            gpb_pkg::IDX_PORT_B_DIR: port_b_direction <= pwdata[7:0];
            gpb_pkg::IDX_PORT_C_DIR: port_c_direction <= pwdata[6:0]; // R3 R22
            gpb_pkg::IDX_PORT_D_DIR: port_d_direction <= pwdata[7:0];
            default: ;
         endcase
      end
   end

   // Per-pin pullup enable bits
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         port_c_pullup_enable <= gpb_pkg::CTRL_RESET[6:0];
         port_d_pullup_enable <= gpb_pkg::CTRL_RESET;
      end else if (ce && wr_en) begin
         case (acc_idx)
            gpb_pkg::IDX_PORT_C_PUE: port_c_pullup_enable <= pwdata[6:0]; // R9 R22
            gpb_pkg::IDX_PORT_D_PUE: port_d_pullup_enable <= pwdata[7:0];
            default: ;
         endcase
      end
   end

   // ****************************************
   // Alternate function ownership
   // ****************************************

   // CAN takes receive on bit 1 and transmit on bit 0
   always_comb begin
      pc_own = '0;
      pc_alt_oe = '0;
      pc_alt_out = '0;
      pc_own[gpb_pkg::PC_CAN_RX] = can_pin_enable; // R10
      pc_own[gpb_pkg::PC_CAN_TX] = can_pin_enable; // R10
      pc_alt_oe[gpb_pkg::PC_CAN_TX] = 1'b1;
      pc_alt_out[gpb_pkg::PC_CAN_TX] = can_tx;
   end

   // SPI takes bits 3..1, slave select only outside master mode
   always_comb begin
      spi_own = {gpb_pkg::SPI_PINS{spi_enable_bit}}; // R14 R15 R16
      spi_own[gpb_pkg::PD_SPI_SS] = spi_enable_bit & ~spi_master_select; // R18
   end

   // Timer channels claim bits 7..4 by their select pairs
   always_comb begin
      for (int k = 0; k < gpb_pkg::TIMER_CHANS; k++) begin
         tim_own[k] = chan_active(edge_level_select, k); // R13
      end
   end

   // Owned port D pins follow their peripheral, not direction
   always_comb begin
      pd_own = {tim_own, spi_own}; // R11
      pd_alt_oe = {timer_pin_oe, spi_pin_oe}; // R17
      pd_alt_out = {timer_pin_out, spi_pin_out};
   end

   // ****************************************
   // Pin muxes
   // ****************************************

   // Port B: plain I/O, no pullups
   gpb_pin_mux #(.W(gpb_pkg::PB_W)) u_mux_b (
      .latch(port_b_latch),
      .dir(port_b_direction),
      .pue('0),
      .alt_own('0),
      .alt_oe('0),
      .alt_out('0),
      .pin_in(port_b_pin_in),
      .next_oe(next_b_oe),
      .next_out(next_b_out),
      .next_pullup(),
      .rd_val(b_rd)
   );

   // Port C: seven pins shared with CAN
   gpb_pin_mux #(.W(gpb_pkg::PC_W)) u_mux_c (
      .latch(port_c_latch),
      .dir(port_c_direction),
      .pue(port_c_pullup_enable),
      .alt_own(pc_own),
      .alt_oe(pc_alt_oe),
      .alt_out(pc_alt_out),
      .pin_in(port_c_pin_in),
      .next_oe(next_c_oe),
      .next_out(next_c_out),
      .next_pullup(next_c_pullup),
      .rd_val(c_rd)
   );

   // Port D: shared with SPI and timers
   gpb_pin_mux #(.W(gpb_pkg::PD_W)) u_mux_d (
      .latch(port_d_latch),
      .dir(port_d_direction),
      .pue(port_d_pullup_enable),
      .alt_own(pd_own),
      .alt_oe(pd_alt_oe),
      .alt_out(pd_alt_out),
      .pin_in(port_d_pin_in),
      .next_oe(next_d_oe),
      .next_out(next_d_out),
      .next_pullup(next_d_pullup),
      .rd_val(d_rd)
   );

   // ****************************************
   // Registered pin outputs
   // ****************************************

   // Port B drive
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         port_b_pin_oe <= '0;
         port_b_pin_out <= '0;
      end else if (ce) begin
         port_b_pin_oe <= next_b_oe;
         port_b_pin_out <= next_b_out;
      end
   end

   // Port C drive and pullups
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         port_c_pin_oe <= '0;
         port_c_pin_out <= '0;
         port_c_pullup <= '0;
      end else if (ce) begin
         port_c_pin_oe <= next_c_oe; // R5
         port_c_pin_out <= next_c_out; // R5
         port_c_pullup <= next_c_pullup; // R8
      end
   end

   // Port D drive and pullups
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         port_d_pin_oe <= '0;
         port_d_pin_out <= '0;
         port_d_pullup <= '0;
      end else if (ce) begin
         port_d_pin_oe <= next_d_oe; // R17
         port_d_pin_out <= next_d_out;
         port_d_pullup <= next_d_pullup; // R21
      end
   end

   // Pin levels handed to CAN, SPI and timer inputs
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         can_rx <= 1'b0;
         port_d_pin_level <= '0;
      end else if (ce) begin
         can_rx <= port_c_pin_in[gpb_pkg::PC_CAN_RX];
         port_d_pin_level <= port_d_pin_in;
      end
   end

endmodule

`default_nettype wire

// [test/gpb_gpio_ports_props.sv]
// Checker for the port B, C and D pin logic
`timescale 1ns/1ps
`default_nettype none
module gpb_gpio_ports_props (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [6:0] port_c_pin_in,
   input wire logic [6:0] port_c_pin_out,
   input wire logic [6:0] port_c_pin_oe,
   input wire logic [6:0] port_c_pullup,
   input wire logic [7:0] port_d_pin_in,
   input wire logic [7:0] port_d_pin_oe,
   input wire logic [7:0] port_d_pullup,
   input wire logic can_pin_enable,
   input wire logic can_tx,
   input wire logic can_rx,
   input wire logic spi_enable_bit,
   input wire logic spi_master_select,
   input wire logic [3:0] spi_pin_oe,
   input wire logic [7:0] edge_level_select,
   input wire logic [3:0] timer_pin_oe,
   input wire logic [7:0] port_d_pin_level
);
   // ****************************************
   // Bus and pin relations
   // ****************************************
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   property p_rdy; psel && !penable && ce |=> pready ##1 !pready; endproperty
   a_rdy: assert property (p_rdy) else $error("ready not one cycle after setup");
   property p_err; pslverr |-> pready; endproperty
   a_err: assert property (p_err) else $error("error without ready");
   property p_c_drv; (port_c_pin_out & ~port_c_pin_oe) == 7'h00; endproperty
   a_c_drv: assert property (p_c_drv) else $error("port c drives while off");
   property p_c_pu; (port_c_pullup & port_c_pin_oe) == 7'h00; endproperty
   a_c_pu: assert property (p_c_pu) else $error("port c pullup on output");
   property p_d_pu; (port_d_pullup & port_d_pin_oe) == 8'h00; endproperty
   a_d_pu: assert property (p_d_pu) else $error("port d pullup on output");
   property p_can;
      can_pin_enable && ce |=> port_c_pin_oe[1:0] == 2'b01 && port_c_pin_out[0] == $past(can_tx);
   endproperty
   a_can: assert property (p_can) else $error("can pins not handed over");
   property p_can_rx; ce |=> can_rx == $past(port_c_pin_in[1]); endproperty
   a_can_rx: assert property (p_can_rx) else $error("can receive not passed");
   property p_spi; spi_enable_bit && ce |=> port_d_pin_oe[3:1] == $past(spi_pin_oe[3:1]);
   endproperty
   a_spi: assert property (p_spi) else $error("spi pins not owned");
   property p_ss;
      spi_enable_bit && !spi_master_select && ce |=> port_d_pin_oe[0] == $past(spi_pin_oe[0]);
   endproperty
   a_ss: assert property (p_ss) else $error("slave select not owned");
   property p_tmr; (|edge_level_select[7:6]) && ce |=> port_d_pin_oe[7] == $past(timer_pin_oe[3]);
   endproperty
   a_tmr: assert property (p_tmr) else $error("timer pin not owned");
   property p_lvl; ce |=> port_d_pin_level == $past(port_d_pin_in); endproperty
   a_lvl: assert property (p_lvl) else $error("port d level not passed");
endmodule
bind gpb_gpio_ports gpb_gpio_ports_props u_gpb_gpio_ports_props (.*);
`default_nettype wire

// [test/gpb_pin_model.sv]
// Pad model for one port: own driver, outside source, pullup, float
`timescale 1ns/1ps
`default_nettype none
module gpb_pin_model #(
   parameter int W = 8
) (
   input wire logic clk,
   input wire logic [W-1:0] oe,
   input wire logic [W-1:0] out,
   input wire logic [W-1:0] pull_en,
   input wire logic [W-1:0] ext_en,
   input wire logic [W-1:0] ext_val,
   output logic [W-1:0] pin
);
   // Floating pins wander every cycle
   logic [W-1:0] drift = '0;
   always @(posedge clk) begin
      drift <= ~drift;
   end
   // Own driver wins, then outside source, then pullup
   assign pin = (oe & out) | (~oe & ext_en & ext_val) | (~oe & ~ext_en & pull_en)
      | (~oe & ~ext_en & ~pull_en & drift);
endmodule
`default_nettype wire

// [test/gpb_gpio_ports_tb.sv]
// Self-checking bench for the port B, C and D pin logic
`timescale 1ns/1ps
`default_nettype none
module gpb_gpio_ports_tb;
   // ****************************************
   // Signals and instances
   // ****************************************
   logic clk = 1'b0, rstn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic pready, pslverr, can_rx;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic [3:0] pstrb = 4'hf;
   logic [7:0] b_in, b_out, b_oe, d_in, d_out, d_oe, d_pu, d_lvl;
   logic [6:0] c_in, c_out, c_oe, c_pu;
   logic [7:0] b_xen = 8'h00, b_xv = 8'h00, els = 8'h00;
   logic [6:0] c_xen = 7'h00, c_xv = 7'h00;
   logic can_en = 1'b0, can_tx = 1'b0, spi_en = 1'b0, spi_ms = 1'b0;
   logic [3:0] spi_oe = 4'h0, spi_out = 4'h0, tmr_oe = 4'h0, tmr_out = 4'h0;
   logic [33:0] q[$];
   logic [33:0] mon_e;
   int n_mismatch = 0;
   int n_compared = 0;
   gpb_gpio_ports u_gpb_gpio_ports (.clk(clk), .rstn(rstn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .port_b_pin_in(b_in),
      .port_b_pin_out(b_out), .port_b_pin_oe(b_oe), .port_c_pin_in(c_in),
      .port_c_pin_out(c_out), .port_c_pin_oe(c_oe), .port_c_pullup(c_pu),
      .port_d_pin_in(d_in), .port_d_pin_out(d_out), .port_d_pin_oe(d_oe),
      .port_d_pullup(d_pu), .can_pin_enable(can_en), .can_tx(can_tx), .can_rx(can_rx),
      .spi_enable_bit(spi_en), .spi_master_select(spi_ms), .spi_pin_oe(spi_oe),
      .spi_pin_out(spi_out), .edge_level_select(els), .timer_pin_oe(tmr_oe),
      .timer_pin_out(tmr_out), .port_d_pin_level(d_lvl));
   gpb_pin_model #(.W(8)) u_gpb_pin_model_b (.clk(clk), .oe(b_oe), .out(b_out),
      .pull_en(8'h00), .ext_en(b_xen), .ext_val(b_xv), .pin(b_in));
   gpb_pin_model #(.W(7)) u_gpb_pin_model_c (.clk(clk), .oe(c_oe), .out(c_out),
      .pull_en(c_pu), .ext_en(c_xen), .ext_val(c_xv), .pin(c_in));
   gpb_pin_model #(.W(8)) u_gpb_pin_model_d (.clk(clk), .oe(d_oe), .out(d_out),
      .pull_en(d_pu), .ext_en(8'h00), .ext_val(8'h00), .pin(d_in));
   always #10 clk = ~clk;
   // ****************************************
   // Tasks
   // ****************************************
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         n_mismatch++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic end_sim();
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Setup cycle, then access until ready; expectation noted first
   task automatic apb(input logic w, input logic [5:0] i, input logic [1:0] lo,
         input logic [31:0] d, input logic [31:0] e, input logic er);
      int n;
      n = 0;
      q.push_back({~w, er, e});
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {i, lo};
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n == 50) n_mismatch++;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [5:0] i, input logic [31:0] d);
      apb(1'b1, i, 2'b00, d, 32'h0, 1'b0);
   endtask
   task automatic rd(input logic [5:0] i, input logic [31:0] e);
      apb(1'b0, i, 2'b00, 32'h0, e, 1'b0);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Answer watcher takes the oldest note at each ready
   always @(posedge clk) begin
      if (pready === 1'b1 && q.size() > 0) begin
         mon_e = q.pop_front();
         chk({31'h0, pslverr}, {31'h0, mon_e[32]});
         if (mon_e[33]) chk(prdata, mon_e[31:0]);
      end
   end
   // Watchdog
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      end_sim();
   end
   // ****************************************
   // Scenarios
   // ****************************************
   initial begin
      logic [7:0] lc, ld, pb;
      void'($urandom(32'h373c));
      lc = $urandom;
      ld = $urandom;
      pb = $urandom;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      rd(gpb_pkg::IDX_PORT_C_DIR, 32'h0);
      rd(gpb_pkg::IDX_PORT_C_PUE, 32'h0);
      wr(gpb_pkg::IDX_PORT_C_LATCH, {24'h0, lc});
      wr(gpb_pkg::IDX_PORT_D_LATCH, {24'h0, ld});
      // Second reset keeps the data latches
      rstn <= 1'b0;
      idle(2);
      rstn <= 1'b1;
      rd(gpb_pkg::IDX_PORT_C_DIR, 32'h0);
      chk({25'h0, c_oe}, 32'h0);
      wr(gpb_pkg::IDX_PORT_C_DIR, 32'hff);
      rd(gpb_pkg::IDX_PORT_C_DIR, 32'h7f);
      rd(gpb_pkg::IDX_PORT_C_LATCH, {25'h0, lc[6:0]});
      wr(gpb_pkg::IDX_PORT_D_DIR, 32'hff);
      rd(gpb_pkg::IDX_PORT_D_LATCH, {24'h0, ld});
      idle(3);
      chk({18'h0, c_oe, c_out}, {18'h0, 7'h7f, lc[6:0]});
      // Port B read-back per direction bit
      b_xen <= 8'hff;
      b_xv <= pb;
      wr(gpb_pkg::IDX_PORT_B_LATCH, {24'h0, ~pb});
      rd(gpb_pkg::IDX_PORT_B_LATCH, {24'h0, pb});
      wr(gpb_pkg::IDX_PORT_B_DIR, 32'h0f);
      rd(gpb_pkg::IDX_PORT_B_LATCH, {24'h0, pb[7:4], ~pb[3:0]});
      // Port C pullups follow enable and direction
      c_xen <= 7'h2a;
      c_xv <= 7'h08;
      wr(gpb_pkg::IDX_PORT_C_PUE, 32'h55);
      wr(gpb_pkg::IDX_PORT_C_DIR, 32'h05);
      idle(3);
      chk({25'h0, c_pu}, 32'h50);
      rd(gpb_pkg::IDX_PORT_C_LATCH, {25'h0, (lc[6:0] & 7'h05) | 7'h58});
      wr(gpb_pkg::IDX_PORT_C_PUE, 32'hff);
      rd(gpb_pkg::IDX_PORT_C_PUE, 32'h7f);
      // CAN takes and returns pins 1 and 0
      wr(gpb_pkg::IDX_PORT_C_DIR, 32'h02);
      can_en <= 1'b1;
      can_tx <= 1'b1;
      idle(3);
      chk({29'h0, c_out[0], c_oe[1:0]}, 32'h5);
      can_en <= 1'b0;
      idle(3);
      chk({30'h0, c_oe[1:0]}, 32'h2);
      // Clock enable low freezes the pin registers
      ce <= 1'b0;
      can_en <= 1'b1;
      idle(3);
      chk({30'h0, c_oe[1:0]}, 32'h2);
      ce <= 1'b1;
      idle(2);
      chk({30'h0, c_oe[1:0]}, 32'h1);
      can_en <= 1'b0;
      // SPI ownership, direction ignored, read-back kept
      wr(gpb_pkg::IDX_PORT_D_DIR, 32'h00);
      spi_en <= 1'b1;
      spi_oe <= 4'b1010;
      spi_out <= 4'b1110;
      idle(3);
      chk({24'h0, d_oe[3:0], d_out[3:0]}, 32'haa);
      wr(gpb_pkg::IDX_PORT_D_DIR, 32'hff);
      idle(3);
      chk({28'h0, d_oe[3:0]}, 32'ha);
      rd(gpb_pkg::IDX_PORT_D_LATCH, {24'h0, ld});
      spi_ms <= 1'b1;
      idle(2);
      chk({28'h0, d_oe[3:0]}, 32'hb);
      spi_en <= 1'b0;
      idle(2);
      chk({28'h0, d_oe[3:0]}, 32'hf);
      // Every nonzero edge/level code claims its timer pin
      wr(gpb_pkg::IDX_PORT_D_DIR, 32'h00);
      tmr_oe <= 4'hf;
      tmr_out <= 4'hf;
      for (int k = 0; k < 4; k++) begin
         for (int v = 1; v < 4; v++) begin
            els <= 8'(v << (2 * k));
            idle(2);
            chk({24'h0, d_oe[7:4], d_out[7:4]}, 32'(8'h11 << k));
         end
      end
      els <= 8'h00;
      // Port D pullups drop on outputs
      wr(gpb_pkg::IDX_PORT_D_PUE, 32'hff);
      wr(gpb_pkg::IDX_PORT_D_DIR, 32'h0f);
      idle(3);
      chk({24'h0, d_pu}, 32'hf0);
      for (int r = 0; r < 4; r++) begin
         ld = $urandom;
         wr(gpb_pkg::IDX_PORT_D_LATCH, {24'h0, ld});
         rd(gpb_pkg::IDX_PORT_D_LATCH, {24'h0, 4'hf, ld[3:0]});
      end
      // Refused accesses
      apb(1'b0, 6'h3f, 2'b00, 32'h0, 32'h0, 1'b1);
      apb(1'b1, gpb_pkg::IDX_PORT_C_PUE, 2'b01, 32'h0, 32'h0, 1'b1);
      pstrb <= 4'h0;
      wr(gpb_pkg::IDX_PORT_C_PUE, 32'h00);
      pstrb <= 4'hf;
      rd(gpb_pkg::IDX_PORT_C_PUE, 32'h7f);
      idle(2);
      end_sim();
   end
endmodule
`default_nettype wire
